// file: design/tmks_map.vh
`ifndef TMKS_MAP_VH
`define TMKS_MAP_VH
`define TMKS_NKEYS 64
`define TMKS_BURST_MAX 7'h40
`define TMKS_SETTLE_CYC 4'h3
`define TMKS_HYS_12 2'h0
`define TMKS_HYS_25 2'h1
`define TMKS_HYS_50 2'h2
`define TMKS_DRIFT_DIV 4'hf
`define TMKS_SPI_CMD_STATUS 2'h0
`define TMKS_SPI_CMD_SIGNAL 2'h1
`define TMKS_SPI_CMD_ERROR 2'h2
`define TMKS_SPI_CMD_REF 2'h3
`endif

// file: design/tmks_spi.v
`timescale 1ns/10ps
`include "tmks_map.vh"
// slave byte port: command byte {op[7:6], key[5:0]}, answer byte on next frame
module tmks_spi (
    input wire clk,
    input wire reset,
    input wire sck_in,
    input wire mosi_in,
    input wire ss_n_in,
    input wire mode_ms,
    output reg miso_out,
    output reg mosi_out,
    output reg mosi_oe,
    output reg [7:0] cmd_reg,
    output reg cmd_valid_reg,
    input wire [7:0] answer
);
    reg [2:0] sck_s_reg;
    reg [1:0] mosi_s_reg;
    reg [2:0] ss_s_reg;
    reg [7:0] sh_reg;
    reg [7:0] tx_reg;
    reg [2:0] cnt_reg;
    reg reply_reg;
    reg taken_reg;
    wire rise = sck_s_reg[1] & ~sck_s_reg[2];
    wire fall = ~sck_s_reg[1] & sck_s_reg[2];
    wire sel = ~ss_s_reg[1];
    wire ss_end = ss_s_reg[1] & ~ss_s_reg[2];
    // link clock is at most 6.25 MHz, so 200 MHz sampling sees every edge
    always @(posedge clk) begin
        if (reset) begin
            sck_s_reg <= 3'h0;
            mosi_s_reg <= 2'h0;
            ss_s_reg <= 3'h7;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            cnt_reg <= 3'h0;
            reply_reg <= 1'b0;
            taken_reg <= 1'b0;
            cmd_reg <= 8'h00;
            cmd_valid_reg <= 1'b0;
            miso_out <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
        end else begin
            sck_s_reg <= {sck_s_reg[1:0], sck_in};
            mosi_s_reg <= {mosi_s_reg[0], mosi_in};
            ss_s_reg <= {ss_s_reg[1:0], ss_n_in};
            cmd_valid_reg <= 1'b0;
            // in master-slave form the answer goes back on the data line
            // only in the frame after a command, so the host's command is never overdriven
            mosi_oe <= mode_ms & reply_reg & sel & ~ss_s_reg[2];
            if (ss_end) begin
                reply_reg <= mode_ms & taken_reg;
                taken_reg <= 1'b0;
            end
            if (!sel) begin
                cnt_reg <= 3'h0;
                tx_reg <= answer;
            end else if (rise) begin
                sh_reg <= {sh_reg[6:0], mosi_s_reg[1]};
                cnt_reg <= cnt_reg + 3'h1;
                // an answer frame carries our own bits back; they are no command
                if (cnt_reg == 3'h7 && !reply_reg) begin
                    cmd_reg <= {sh_reg[6:0], mosi_s_reg[1]};
                    cmd_valid_reg <= 1'b1;
                    taken_reg <= 1'b1;
                end
            end else if (fall) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
            miso_out <= mode_ms ? 1'b0 : tx_reg[7];
            mosi_out <= mode_ms ? tx_reg[7] : 1'b0;
        end
    end
endmodule

// file: design/tmks_top.v
`timescale 1ns/10ps
`include "tmks_map.vh"
module tmks_top (
    input wire clk,
    input wire reset,
    input wire [6:0] burst_len,
    input wire [1:0] cancel_sel,
    input wire [1:0] hys_neg_sel,
    input wire [1:0] hys_pos_sel,
    input wire cfg_we,
    input wire [5:0] cfg_key,
    input wire [7:0] cfg_neg_thr,
    input wire [7:0] cfg_pos_thr,
    input wire [3:0] cfg_det_limit,
    input wire [7:0] adc_in,
    input wire adc_valid,
    input wire sck_in,
    input wire mosi_in,
    input wire ss_n_in,
    input wire mode_ms,
    output reg [7:0] row_drive,
    output reg row_ladder_en,
    output reg [7:0] col_clamp,
    output reg [2:0] col_sel,
    output reg sample_en,
    output reg integ_reset,
    output reg [1:0] charge_cancel_capacitor,
    output reg adc_start,
    output reg [63:0] key_touched,
    output reg [63:0] key_water,
    output reg scan_done,
    output wire miso_out,
    output wire mosi_out,
    output wire mosi_oe
);
    localparam ST_RESET = 3'h0;
    localparam ST_HIGH = 3'h1;
    localparam ST_LOW = 3'h2;
    localparam ST_LADDER = 3'h3;
    localparam ST_CONV = 3'h4;
    localparam ST_EVAL = 3'h5;

    reg [2:0] state_reg;
    reg [5:0] key_reg;
    reg [6:0] pulse_reg;
    reg [3:0] tmr_reg;
    reg [7:0] sig_reg;
    reg [7:0] adc_s_reg;
    reg [7:0] neg_thr [0:63];
    reg [7:0] pos_thr [0:63];
    reg [3:0] det_lim [0:63];
    reg [7:0] ref_mem [0:63];
    reg [7:0] sig_mem [0:63];
    reg [3:0] det_cnt [0:63];
    reg [1:0] err_mem [0:63];
    reg [3:0] drift_reg;
    reg [7:0] answer_reg;
    wire [7:0] cmd;
    wire cmd_valid;
    integer i;

    ////////////////////////////////////////////////////////////////////////////////
    // threshold arithmetic, clamped to the 8-bit window
    function [7:0] sub_clamp;
        input [7:0] a;
        input [7:0] b;
        begin
            sub_clamp = (a > b) ? a - b : 8'h00;
        end
    endfunction
    function [7:0] add_clamp;
        input [7:0] a;
        input [7:0] b;
        reg [8:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            add_clamp = s[8] ? 8'hff : s[7:0];
        end
    endfunction
    function [7:0] hys_amt;
        input [7:0] d;
        input [1:0] sel;
        begin
            case (sel)
                `TMKS_HYS_12: hys_amt = {3'h0, d[7:3]};
                `TMKS_HYS_25: hys_amt = {2'h0, d[7:2]};
                default: hys_amt = {1'b0, d[7:1]};
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // per-key levels from the current reference; recomputed every evaluation
    wire [7:0] cur_ref = ref_mem[key_reg];
    wire [7:0] cur_neg = neg_thr[key_reg];
    wire [7:0] cur_pos = pos_thr[key_reg];
    wire [7:0] neg_lvl = sub_clamp(cur_ref, cur_neg);
    wire [7:0] pos_lvl = add_clamp(cur_ref, cur_pos);
    // drop-out sits between threshold and reference
    wire [7:0] neg_drop = add_clamp(neg_lvl, hys_amt(cur_neg, hys_neg_sel));
    wire [7:0] pos_drop = sub_clamp(pos_lvl, hys_amt(cur_pos, hys_pos_sel));
    wire touched_now = key_touched[key_reg];
    // a falling signal is a touch, a rising one is not
    wire det_hit = touched_now ? (sig_reg < neg_drop) : (sig_reg < neg_lvl);
    wire pos_hit = key_water[key_reg] ? (sig_reg > pos_drop) : (sig_reg > pos_lvl);
    wire [3:0] cur_cnt = det_cnt[key_reg];
    wire [3:0] cur_lim = det_lim[key_reg];

    ////////////////////////////////////////////////////////////////////////////////
    // acquisition sequencer
    always @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_RESET;
            key_reg <= 6'h00;
            pulse_reg <= 7'h00;
            tmr_reg <= 4'h0;
            sig_reg <= 8'h00;
            adc_s_reg <= 8'h00;
            row_drive <= 8'h00;
            row_ladder_en <= 1'b0;
            col_clamp <= 8'h00;
            col_sel <= 3'h0;
            sample_en <= 1'b0;
            integ_reset <= 1'b1;
            charge_cancel_capacitor <= 2'h0;
            adc_start <= 1'b0;
            key_touched <= 64'h0;
            key_water <= 64'h0;
            scan_done <= 1'b0;
            drift_reg <= 4'h0;
            for (i = 0; i < 64; i = i + 1) begin
                neg_thr[i] <= 8'h10;
                pos_thr[i] <= 8'h10;
                det_lim[i] <= 4'h3;
                ref_mem[i] <= 8'h80;
                sig_mem[i] <= 8'h00;
                det_cnt[i] <= 4'h0;
                err_mem[i] <= 2'h0;
            end
        end else begin
            adc_start <= 1'b0;
            scan_done <= 1'b0;
            if (adc_valid)
                adc_s_reg <= adc_in;
            if (cfg_we) begin
                neg_thr[cfg_key] <= cfg_neg_thr;
                pos_thr[cfg_key] <= cfg_pos_thr;
                det_lim[cfg_key] <= cfg_det_limit;
            end
            case (state_reg)
                ST_RESET: begin
                    integ_reset <= 1'b1;
                    row_ladder_en <= 1'b0;
                    row_drive <= 8'h00;
                    col_sel <= key_reg[2:0];
                    col_clamp <= 8'h00;
                    charge_cancel_capacitor <= 2'h0;
                    pulse_reg <= 7'h00;
                    tmr_reg <= tmr_reg + 4'h1;
                    if (tmr_reg == `TMKS_SETTLE_CYC) begin
                        tmr_reg <= 4'h0;
                        integ_reset <= 1'b0;
                        state_reg <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    // rising edge: only this charge reaches the integrator
                    row_drive <= 8'h01 << key_reg[5:3];
                    col_clamp <= 8'h00;
                    sample_en <= 1'b1;
                    // cancellation capacitors act inside the burst
                    charge_cancel_capacitor <= cancel_sel;
                    tmr_reg <= tmr_reg + 4'h1;
                    if (tmr_reg == `TMKS_SETTLE_CYC) begin
                        tmr_reg <= 4'h0;
                        state_reg <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    // falling edge discharges row_column_coupling_capacitance to ground
                    row_drive <= 8'h00;
                    sample_en <= 1'b0;
                    col_clamp <= 8'h01 << key_reg[2:0];
                    tmr_reg <= tmr_reg + 4'h1;
                    if (tmr_reg == `TMKS_SETTLE_CYC) begin
                        tmr_reg <= 4'h0;
                        pulse_reg <= pulse_reg + 7'h1;
                        // burst length clamped to 64; zero treated as one
                        if (pulse_reg + 7'h1 >= ((burst_len > `TMKS_BURST_MAX) ? `TMKS_BURST_MAX :
                            ((burst_len == 7'h00) ? 7'h01 : burst_len)))
                            state_reg <= ST_LADDER;
                        else
                            state_reg <= ST_HIGH;
                    end
                end
                ST_LADDER: begin
                    // row lines are free now that the burst is over
                    col_clamp <= 8'h00;
                    row_ladder_en <= 1'b1;
                    row_drive <= ref_mem[key_reg];
                    tmr_reg <= tmr_reg + 4'h1;
                    if (tmr_reg == `TMKS_SETTLE_CYC) begin
                        tmr_reg <= 4'h0;
                        adc_start <= 1'b1;
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (adc_valid) begin
                        sig_reg <= adc_in;
                        state_reg <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    sig_mem[key_reg] <= sig_reg;
                    err_mem[key_reg] <= {sig_reg == 8'hff, sig_reg == 8'h00};
                    if (cur_lim == 4'h0) begin
                        det_cnt[key_reg] <= 4'h0;
                        key_touched[key_reg] <= 1'b0;
                    end else if (det_hit) begin
                        if (cur_cnt < cur_lim)
                            det_cnt[key_reg] <= cur_cnt + 4'h1;
                        if (cur_cnt + 4'h1 >= cur_lim)
                            key_touched[key_reg] <= 1'b1;
                    end else if (touched_now) begin
                        det_cnt[key_reg] <= cur_cnt - 4'h1;
                        if (cur_cnt <= 4'h1)
                            key_touched[key_reg] <= 1'b0;
                    end else begin
                        det_cnt[key_reg] <= 4'h0;
                    end
                    key_water[key_reg] <= pos_hit;
                    if (pos_hit && !touched_now)
                        ref_mem[key_reg] <= sig_reg;
                    else if (!det_hit && !touched_now && cur_cnt == 4'h0 && drift_reg == 4'h0) begin
                        if (sig_reg > cur_ref)
                            ref_mem[key_reg] <= cur_ref + 8'h01;
                        else if (sig_reg < cur_ref)
                            ref_mem[key_reg] <= cur_ref - 8'h01;
                    end
                    key_reg <= key_reg + 6'h01;
                    if (key_reg == 6'h3f) begin
                        scan_done <= 1'b1;
                        // slow drift: one step every sixteen full scans
                        drift_reg <= drift_reg + 4'h1;
                    end
                    state_reg <= ST_RESET;
                end
                default: state_reg <= ST_RESET;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // host answers
    always @(posedge clk) begin
        if (reset)
            answer_reg <= 8'h00;
        else if (cmd_valid) begin
            case (cmd[7:6])
                `TMKS_SPI_CMD_STATUS: answer_reg <= {6'h00, key_water[cmd[5:0]], key_touched[cmd[5:0]]};
                `TMKS_SPI_CMD_SIGNAL: answer_reg <= sig_mem[cmd[5:0]];
                `TMKS_SPI_CMD_ERROR: answer_reg <= {6'h00, err_mem[cmd[5:0]]};
                default: answer_reg <= ref_mem[cmd[5:0]];
            endcase
        end
    end

    tmks_spi u_spi (
        .clk(clk),
        .reset(reset),
        .sck_in(sck_in),
        .mosi_in(mosi_in),
        .ss_n_in(ss_n_in),
        .mode_ms(mode_ms),
        .miso_out(miso_out),
        .mosi_out(mosi_out),
        .mosi_oe(mosi_oe),
        .cmd_reg(cmd),
        .cmd_valid_reg(cmd_valid),
        .answer(answer_reg)
    );
endmodule

// file: sim/tmks_host.sv
`timescale 1ns/10ps
// behavioural host; its clock stands low between frames
module tmks_host (
    output logic sck,
    output logic ss_n,
    output logic mosi_drv,
    output logic mosi_en,
    input wire logic miso,
    input wire logic mosi_line,
    input wire logic ms
);
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi_drv = 1'b0;
        mosi_en = 1'b1;
    end
    // one byte, msb first; drv low leaves the shared line to the device
    task automatic frame(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
        mosi_en = drv;
        ss_n = 1'b0;
        #160;
        for (int i = 7; i >= 0; i--) begin
            mosi_drv = tx[i];
            #80 sck = 1'b1;
            rx[i] = ms ? mosi_line : miso;
            #80 sck = 1'b0;
        end
        #80 ss_n = 1'b1;
        mosi_drv = ~mosi_drv;
        // take the shared line back only once the device has let go of it
        #400;
        mosi_en = 1'b1;
    endtask
endmodule

// file: sim/tmks_top_chk.sv
`timescale 1ns/10ps
module tmks_chk (
    input wire clk,
    input wire reset,
    input wire [7:0] row_drive,
    input wire row_ladder_en,
    input wire [7:0] col_clamp,
    input wire [2:0] col_sel,
    input wire sample_en,
    input wire integ_reset,
    input wire [1:0] charge_cancel_capacitor,
    input wire adc_start,
    input wire adc_valid,
    input wire [63:0] key_touched
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    reg [6:0] pulse_reg;
    reg gate_reg;
    // integrator reset opens each key, so the count is per key
    always @(posedge clk) begin
        gate_reg <= sample_en;
        if (reset || integ_reset) begin
            pulse_reg <= 7'h00;
        end else if (sample_en && !gate_reg) begin
            pulse_reg <= pulse_reg + 7'h01;
        end
    end
    sequence s_ladder_run;
        row_ladder_en [*4];
    endsequence
    sequence s_ladder_end;
        row_ladder_en ##1 !row_ladder_en;
    endsequence
    ////////////////////////////////
    a_gate_clamp:
        assert property (!(sample_en && |col_clamp)) else $error("gate and clamp overlap");
    a_gate_row:
        assert property (sample_en |-> $onehot(row_drive) && !integ_reset && !row_ladder_en)
        else $error("gate outside burst");
    a_clamp_col:
        assert property (|col_clamp |-> col_clamp == (8'h01 << col_sel)) else $error("wrong clamp");
    a_ladder_quiet:
        assert property (row_ladder_en |-> !sample_en && col_clamp == 8'h00) else $error("ladder overlap");
    a_ladder_len:
        assert property ($rose(row_ladder_en) |-> s_ladder_run ##0 adc_start) else $error("ladder len");
    a_adc_after:
        assert property (adc_start |-> row_ladder_en && !sample_en) else $error("conversion outside ladder");
    a_ladder_release:
        assert property (s_ladder_end |-> integ_reset) else $error("ladder dropped mid key");
    a_cancel_idle:
        assert property (integ_reset |-> charge_cancel_capacitor == 2'h0) else $error("cancel outside burst");
    a_adc_pulse:
        assert property (adc_start |=> !adc_start) else $error("long start");
    a_eval_late:
        assert property ($changed(key_touched) |-> $past(adc_valid) || $past(adc_valid, 2) || $past(adc_valid, 3))
        else $error("state change without eval");
    a_burst_max:
        assert property (pulse_reg <= 7'h40) else $error("burst too long");
endmodule
bind tmks_top tmks_chk u_chk (.clk, .reset, .row_drive, .row_ladder_en, .col_clamp, .col_sel,
    .sample_en, .integ_reset, .charge_cancel_capacitor, .adc_start, .adc_valid, .key_touched);

// file: sim/tmks_top_tb.sv
`timescale 1ns/10ps
module tmks_top_tb;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [6:0] burst_len = 7'h01;
    logic [1:0] cancel_sel = 2'h0;
    logic [1:0] hys_neg_sel = 2'h0;
    logic [1:0] hys_pos_sel = 2'h0;
    logic cfg_we = 1'b0;
    logic [5:0] cfg_key = 6'h00;
    logic [7:0] cfg_neg_thr = 8'h10;
    logic [7:0] cfg_pos_thr = 8'h10;
    logic [3:0] cfg_det_limit = 4'h3;
    logic [7:0] adc_in = 8'h00;
    logic adc_valid = 1'b0;
    logic mode_ms = 1'b0;
    wire sck_in, ss_n_in, h_drv, h_en, mosi_in, miso_out, mosi_out, mosi_oe;
    wire row_ladder_en, sample_en, integ_reset, adc_start, scan_done;
    wire [7:0] row_drive, col_clamp;
    wire [2:0] col_sel;
    wire [1:0] charge_cancel_capacitor;
    wire [63:0] key_touched, key_water;
    logic [7:0] sig [64];
    logic [7:0] rx, hv;
    logic [5:0] cur_key = 6'h00, exp_key = 6'h00;
    logic [6:0] pulses = 7'h00;
    logic gate_d = 1'b0;
    logic [7:0] rq [4] = '{8'h21, 8'h61, 8'h94, 8'hc0};
    logic [7:0] ra [4] = '{8'h01, 8'h6f, 8'h01, 8'h80};
    integer seed, fail_count = 0, compares = 0;
    // a released line shows a toggling pattern, never a stale bit
    assign mosi_in = mosi_oe ? mosi_out : (h_en ? h_drv : clk);
    always #2.5 clk = ~clk;
    tmks_top DUT (.clk, .reset, .burst_len, .cancel_sel, .hys_neg_sel, .hys_pos_sel, .cfg_we, .cfg_key,
        .cfg_neg_thr, .cfg_pos_thr, .cfg_det_limit, .adc_in, .adc_valid, .sck_in, .mosi_in, .ss_n_in,
        .mode_ms, .row_drive, .row_ladder_en, .col_clamp, .col_sel, .sample_en, .integ_reset,
        .charge_cancel_capacitor, .adc_start, .key_touched, .key_water, .scan_done, .miso_out,
        .mosi_out, .mosi_oe);
    tmks_host host (.sck(sck_in), .ss_n(ss_n_in), .mosi_drv(h_drv), .mosi_en(h_en), .miso(miso_out),
        .mosi_line(mosi_in), .ms(mode_ms));
    ////////////////////////////////
    function automatic logic [2:0] row_idx(input logic [7:0] v);
        row_idx = 3'h0;
        for (int i = 0; i < 8; i++) if (v[i]) row_idx = i[2:0];
    endfunction
    function automatic logic [6:0] exp_pulses(input logic [6:0] b);
        return b == 7'h00 ? 7'h01 : (b > 7'h40 ? 7'h40 : b);
    endfunction
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cfg(input logic [5:0] k, input logic [7:0] n, input logic [3:0] l);
        cfg_key = k;
        cfg_neg_thr = n;
        cfg_det_limit = l;
        cfg_we = 1'b1;
        cyc(1);
        cfg_we = 1'b0;
        cyc(1);
    endtask
    task automatic scan(input int n, input logic [6:0] b = 7'h00);
        int t;
        repeat (n) begin
            t = 0;
            burst_len = (b != 7'h00) ? b : 7'($unsigned($random(seed)) % 3);
            cancel_sel = 2'($random(seed));
            hys_pos_sel = 2'($random(seed));
            do begin
                cyc(1);
                t++;
            end while (scan_done !== 1'b1 && t < 40000);
            if (t >= 40000) begin
                fail_count++;
                complete_run;
            end
            cyc(1);
        end
    endtask
    // front end: answers each conversion start one cycle later with the scanned key's level
    always @(posedge clk) begin
        adc_valid <= 1'b0;
        gate_d <= sample_en;
        if (reset) begin
            exp_key <= 6'h00;
        end else begin
            if (sample_en && !gate_d) pulses <= pulses + 7'h01;
            if (integ_reset) pulses <= 7'h00;
            if (sample_en) cur_key <= {row_idx(row_drive), col_sel};
            if (adc_start) begin
                check(cur_key, exp_key, "scan order");
                check(pulses, exp_pulses(burst_len), "burst");
                check(charge_cancel_capacitor, cancel_sel, "cancel");
                adc_in <= sig[cur_key];
                adc_valid <= 1'b1;
                exp_key <= exp_key + 6'h01;
            end
        end
    end
    ////////////////////////////////
    initial begin
        seed = 32'h282d;
        for (int k = 0; k < 64; k++) sig[k] = 8'h78 + 8'($unsigned($random(seed)) % 17);
        sig[0] = 8'h80;
        sig[9] = 8'h80;
        sig[20] = 8'h00;
        sig[33] = 8'h6f;
        sig[50] = 8'h91;
        sig[51] = 8'h90;
        cyc(3);
        check(integ_reset, 1, "reset");
        reset = 1'b0;
        cfg(6'd9, 8'h40, 4'h1);
        cfg(6'd20, 8'h10, 4'h0);
        for (int s = 1; s <= 6; s++) begin
            sig[40] = s == 3 ? 8'h80 : 8'h6f;
            scan(1);
            check(key_touched[33], s >= 3, "integrate");
            check(key_touched[40], s == 6, "restart");
            check(key_touched & ~(64'h1 << 33 | 64'h1 << 40), 0, "idle");
            if (s == 1) check(key_water, 64'h1 << 50, "water");
        end
        for (int m = 0; m < 2; m++) begin
            mode_ms = m[0];
            for (int i = 0; i < 4; i++) begin
                host.frame(rq[i], 1'b1, rx);
                host.frame(8'h00, !mode_ms, rx);
                check(rx, ra[i], "link");
            end
        end
        // the scan ran on during the link traffic; start the next part on a scan boundary
        scan(1);
        for (int h = 0; h < 3; h++) begin
            hys_neg_sel = h[1:0];
            hv = 8'h40 >> (3 - h);
            sig[9] = 8'h30;
            scan(1);
            check(key_touched[9], 1, "on");
            sig[9] = 8'h3e + hv;
            scan(2);
            check(key_touched[9], 1, "hold");
            sig[9] = 8'h40 + hv;
            scan(3);
            check(key_touched[9], 0, "drop");
            sig[9] = 8'h80;
            scan(1);
        end
        // over-long burst request must be cut to the maximum
        scan(1, 7'h7f);
        complete_run;
    end
endmodule
